// ==== verilog/pwc_pkg.sv ====
package pwc_pkg;
  // ----------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] OFS_CONTROL = 8'h34;
  localparam logic [7:0] OFS_CLKSEL = 8'h35;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h36;
  localparam logic [7:0] OFS_RESULT_LOW = 8'h37;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h38;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h39;
  localparam int ADDR_W = 10;

  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int CTL_START = 7;
  localparam int CTL_OVF = 6;
  localparam int CTL_FRONT = 5;
  localparam int CTL_BACK = 4;
  localparam int CTL_SRC_LO = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // ----------------------------------------
  // clock select register fields
  // ----------------------------------------
  localparam int CS_CLK_LO = 2;
  localparam int CS_DIV_LO = 0;
  localparam logic [3:0] CS_RESET = 4'h0;

  // ----------------------------------------
  // codes
  // ----------------------------------------
  localparam logic [2:0] SRC_PIN_A0 = 3'h0;
  localparam logic [2:0] SRC_PIN_A5 = 3'h1;
  localparam logic [2:0] SRC_PIN_A6 = 3'h2;
  localparam logic [2:0] SRC_PIN_B0 = 3'h3;
  localparam logic [2:0] SRC_PIN_B7 = 3'h4;
  localparam logic [2:0] SRC_CMP = 3'h5;
  localparam logic [1:0] CLK_SYS = 2'h0;
  localparam logic [1:0] CLK_RC = 2'h1;
  localparam logic [1:0] CLK_OSC = 2'h2;
  localparam logic [5:0] DIV1_MASK = 6'h00;
  localparam logic [5:0] DIV4_MASK = 6'h03;
  localparam logic [5:0] DIV16_MASK = 6'h0f;
  localparam logic [5:0] DIV64_MASK = 6'h3f;

  // ----------------------------------------
  // interrupt status bits
  // ----------------------------------------
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVF = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  typedef enum logic [2:0] {
    PWC_IDLE = 3'b001,
    PWC_ARMED = 3'b010,
    PWC_COUNT = 3'b100
  } pwc_state_e;
endpackage

// ==== verilog/pwc_capture.sv ====
`timescale 1ns/10ps
// Operation
// - writing one to start begins capture; hardware clears it when finished
// - overflow flag set whenever the capture counter wraps during measurement
// - front edge select: zero rising, one falling opens the measurement
// - back edge select: zero rising, one falling closes the measurement
// - source field picks five port pins or comparator; other codes reserved
// - clock field picks system, fast internal rc or external oscillator clock
// - divider field pre-divides counting clock by 1, 4, 16 or 64
// - result high byte readable at location 0x36
// - result low byte readable at location 0x37
module pwc_capture (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pwc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port_a_pin_zero,
  input wire logic port_a_pin_five,
  input wire logic port_a_pin_six,
  input wire logic port_b_pin_zero,
  input wire logic port_b_pin_seven,
  input wire logic comparatorOut,
  input wire logic fast_internal_rc_clock,
  input wire logic external_oscillator_clock,
  output logic irq
);
  import pwc_pkg::*;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // bits 0..5: measured inputs, 6: rc clock, 7: oscillator clock
  localparam int NIN = 8;
  logic [NIN-1:0] rawIn;
  logic [NIN-1:0] sync1_r;
  logic [NIN-1:0] sync2_r;
  logic [NIN-1:0] sync3_r;
  logic [NIN-1:0] stable_r;
  logic [NIN-1:0] stable_nxt;
  logic [NIN-1:0] rise;
  logic [NIN-1:0] fall;

  assign rawIn = {external_oscillator_clock, fast_internal_rc_clock, comparatorOut,
                  port_b_pin_seven, port_b_pin_zero, port_a_pin_six, port_a_pin_five,
                  port_a_pin_zero};
  // a change is taken only once stages two and three agree
  assign stable_nxt = (sync2_r & sync3_r) | (stable_r & (sync2_r | sync3_r));
  assign rise = stable_nxt & ~stable_r;
  assign fall = ~stable_nxt & stable_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      stable_r <= '0;
    end else begin
      sync1_r <= rawIn;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      stable_r <= stable_nxt;
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic edgeHit(input logic r, input logic f, input logic selFall);
    edgeHit = selFall ? f : r;
  endfunction

  function automatic logic [5:0] divMask(input logic [1:0] code);
    case (code)
      2'h0: divMask = DIV1_MASK;
      2'h1: divMask = DIV4_MASK;
      2'h2: divMask = DIV16_MASK;
      default: divMask = DIV64_MASK;
    endcase
  endfunction

  // edge strobe of the routed input; reserved codes never see an edge
  function automatic logic srcEdge(input logic [2:0] code, input logic [5:0] ev);
    case (code)
      SRC_PIN_A0: srcEdge = ev[0];
      SRC_PIN_A5: srcEdge = ev[1];
      SRC_PIN_A6: srcEdge = ev[2];
      SRC_PIN_B0: srcEdge = ev[3];
      SRC_PIN_B7: srcEdge = ev[4];
      SRC_CMP: srcEdge = ev[5];
      default: srcEdge = 1'b0;
    endcase
  endfunction

  // one tick of the counting clock ahead of the divider
  function automatic logic clkTick(input logic [1:0] code, input logic rcRise,
                                   input logic oscRise);
    case (code)
      CLK_SYS: clkTick = 1'b1;
      CLK_RC: clkTick = rcRise;
      CLK_OSC: clkTick = oscRise;
      default: clkTick = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic startBit_r;
  logic ovfBit_r;
  logic frontFall_r;
  logic backFall_r;
  logic [2:0] srcSel_r;
  logic [1:0] clkSel_r;
  logic [1:0] divSel_r;
  logic [15:0] result_r;
  logic [15:0] count_r;
  logic [5:0] preCnt_r;
  logic [1:0] irqStatus_r;
  logic [1:0] irqMask_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;
  pwc_state_e state_r;
  pwc_state_e state_nxt;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire aligned = (paddr[1:0] == 2'h0);
  wire [7:0] regIdx = paddr[ADDR_W-1:2];
  wire hitCtl = aligned && (regIdx == OFS_CONTROL);
  wire hitCs = aligned && (regIdx == OFS_CLKSEL);
  wire hitRh = aligned && (regIdx == OFS_RESULT_HIGH);
  wire hitRl = aligned && (regIdx == OFS_RESULT_LOW);
  wire hitSt = aligned && (regIdx == OFS_IRQ_STATUS);
  wire hitMk = aligned && (regIdx == OFS_IRQ_MASK);
  wire mapped = hitCtl | hitCs | hitRh | hitRl | hitSt | hitMk;
  // answer one cycle into the access phase
  wire accessFirst = psel && penable && !pready_r;
  wire commit = psel && penable && pready_r;
  wire wrCtl = commit && pwrite && hitCtl;
  wire wrCs = commit && pwrite && hitCs;
  wire wrSt = commit && pwrite && hitSt;
  wire wrMk = commit && pwrite && hitMk;

  wire [7:0] ctlView = {startBit_r, ovfBit_r, frontFall_r, backFall_r, 1'b0, srcSel_r};
  wire [7:0] rdCtl = hitCtl ? ctlView : 8'h00;
  wire [7:0] rdRh = hitRh ? result_r[15:8] : 8'h00;
  wire [7:0] rdRl = hitRl ? result_r[7:0] : 8'h00;
  wire [7:0] rdSt = hitSt ? {6'h00, irqStatus_r} : 8'h00;
  wire [7:0] rdMk = hitMk ? {6'h00, irqMask_r} : 8'h00;
  // clock select is write-only, so it adds nothing to the read path
  wire [7:0] readByte = rdCtl | rdRh | rdRl | rdSt | rdMk;

  // ----------------------------------------
  // measurement path
  // ----------------------------------------
  wire srcRise = srcEdge(srcSel_r, rise[5:0]);
  wire srcFall = srcEdge(srcSel_r, fall[5:0]);
  wire frontHit = edgeHit(srcRise, srcFall, frontFall_r);
  wire backHit = edgeHit(srcRise, srcFall, backFall_r);

  // rc and oscillator ticks follow the synchronised rising edge, so they
  // must run well below half of clk to be counted faithfully
  wire srcTick = clkTick(clkSel_r, rise[6], rise[7]);
  wire [5:0] mask = divMask(divSel_r);
  wire divTick = srcTick && ((preCnt_r & mask) == mask);
  wire counting = (state_r == PWC_COUNT);
  wire wrapEv = counting && !backHit && divTick && (count_r == 16'hffff);
  wire doneEv = counting && backHit;
  wire startReq = wrCtl && pwdata[CTL_START] && (state_r == PWC_IDLE);
  wire abortReq = wrCtl && !pwdata[CTL_START];

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PWC_IDLE: begin
        if (startReq) begin
          state_nxt = PWC_ARMED;
        end
      end
      PWC_ARMED: begin
        if (abortReq) begin
          state_nxt = PWC_IDLE;
        end else if (frontHit) begin
          state_nxt = PWC_COUNT;
        end
      end
      PWC_COUNT: begin
        if (abortReq || backHit) begin
          state_nxt = PWC_IDLE;
        end
      end
      default: state_nxt = PWC_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= PWC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // counter and result
  // ----------------------------------------
  wire frontStart = (state_r == PWC_ARMED) && frontHit;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      preCnt_r <= '0;
    end else if (frontStart) begin
      preCnt_r <= '0;
    end else if (counting && !backHit && srcTick) begin
      preCnt_r <= preCnt_r + 6'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= RESULT_RESET;
    end else if (frontStart) begin
      count_r <= '0;
    end else if (counting && !backHit && divTick) begin
      count_r <= count_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_r <= RESULT_RESET;
    end else if (doneEv) begin
      result_r <= count_r;
    end
  end

  // ----------------------------------------
  // control and clock select
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      startBit_r <= CTL_RESET[CTL_START];
    end else begin
      startBit_r <= (state_nxt != PWC_IDLE);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovfBit_r <= CTL_RESET[CTL_OVF];
    end else if (wrapEv) begin
      ovfBit_r <= 1'b1;  // set wins over a clearing write
    end else if (wrCtl && !pwdata[CTL_OVF]) begin
      ovfBit_r <= 1'b0;
    end
  end

  // a start while busy is ignored, but the field bits still land
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frontFall_r <= CTL_RESET[CTL_FRONT];
      backFall_r <= CTL_RESET[CTL_BACK];
      srcSel_r <= CTL_RESET[CTL_SRC_LO +: 3];
    end else if (wrCtl) begin
      frontFall_r <= pwdata[CTL_FRONT];
      backFall_r <= pwdata[CTL_BACK];
      srcSel_r <= pwdata[CTL_SRC_LO +: 3];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clkSel_r <= CS_RESET[CS_CLK_LO +: 2];
      divSel_r <= CS_RESET[CS_DIV_LO +: 2];
    end else if (wrCs) begin
      clkSel_r <= pwdata[CS_CLK_LO +: 2];
      divSel_r <= pwdata[CS_DIV_LO +: 2];
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  wire [1:0] events = {wrapEv, doneEv};
  wire [1:0] stClear = wrSt ? pwdata[1:0] : 2'h0;
  // a new event outranks a clearing write in the same cycle
  wire [1:0] stNext = (irqStatus_r & ~stClear) | events;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqStatus_r <= IRQ_RESET;
    end else begin
      irqStatus_r <= stNext;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqMask_r <= IRQ_RESET;
    end else if (wrMk) begin
      irqMask_r <= pwdata[1:0];
    end
  end

  // built from the next status so the line rises with the sticky bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stNext & irqMask_r);
    end
  end

  // ----------------------------------------
  // apb answer
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= accessFirst;
      pslverr_r <= accessFirst && !mapped;
      if (accessFirst) begin
        prdata_r <= {24'h000000, readByte};
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
endmodule // pwc_capture

// ==== sim/pwc_capture_asserts.sv ====
`timescale 1ns/10ps
// ----
// port checks: bus timing and capture register map
// ----
module pwc_capture_asserts
  import pwc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pwc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("ready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  property p_idle; !psel |-> !pready; endproperty
  a_idle: assert property (p_idle) else $error("ready without select");
  property p_misal; pready && paddr[1:0] != 2'b00 |-> pslverr; endproperty
  a_misal: assert property (p_misal) else $error("misaligned not refused");
  property p_res; pready && (paddr == {OFS_RESULT_HIGH, 2'b00} ||
    paddr == {OFS_RESULT_LOW, 2'b00}) |-> !pslverr; endproperty
  a_res: assert property (p_res) else $error("result refused");
  property p_wo; pready && !pwrite && paddr == {OFS_CLKSEL, 2'b00} |-> prdata == 32'h0; endproperty
  a_wo: assert property (p_wo) else $error("clock select readable");
  property p_upper; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_errd; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_errd: assert property (p_errd) else $error("refused read not zero");
  // masked status must drop the line within two edges
  property p_mask; pready && pwrite && !pslverr && paddr == {OFS_IRQ_MASK, 2'b00} &&
    pwdata[1:0] == 2'b00 |=> ##1 !irq; endproperty
  a_mask: assert property (p_mask) else $error("irq despite mask");
endmodule // pwc_capture_asserts

bind pwc_capture pwc_capture_asserts pwc_capture_asserts_inst (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// ==== sim/pwc_pulse_src.sv ====
`timescale 1ns/10ps
// ----
// pulse source on one pin, slow clocks free running
// ----
module pwc_pulse_src (
  input wire logic clk,
  input wire logic [2:0] sel,
  input wire logic level,
  output logic [5:0] pin = 6'h00,
  output logic rcClk,
  output logic oscClk
);
  logic [3:0] cnt = 4'h0;
  // unselected pins idle low, like a pulled-down line
  always @(posedge clk) begin
    cnt <= cnt + 4'h1;
    pin <= 6'h00;
    pin[sel] <= level;
  end
  // oscillators well under half the bus clock, so each edge is seen
  assign rcClk = cnt[2];
  assign oscClk = cnt[3];
endmodule // pwc_pulse_src

// ==== sim/pwc_capture_tb.sv ====
`timescale 1ns/10ps
module pwc_capture_tb;
  import pwc_pkg::*;
  localparam logic [9:0] ACTL = {OFS_CONTROL, 2'b00};
  localparam logic [9:0] ACS = {OFS_CLKSEL, 2'b00};
  localparam logic [9:0] AST = {OFS_IRQ_STATUS, 2'b00};
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lvl = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, irq, erv, rcClk, oscClk;
  logic [2:0] sel = 3'h0;
  logic [5:0] pin;
  logic [15:0] res;
  int failCount = 0, samplesChecked = 0, cyc = 0, i;
  always #20 clk = ~clk;
  pwc_capture pwc_capture_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_a_pin_zero(pin[0]), .port_a_pin_five(pin[1]),
    .port_a_pin_six(pin[2]), .port_b_pin_zero(pin[3]), .port_b_pin_seven(pin[4]),
    .comparatorOut(pin[5]), .fast_internal_rc_clock(rcClk),
    .external_oscillator_clock(oscClk), .irq(irq));
  pwc_pulse_src pwc_pulse_src_inst (.clk(clk), .sel(sel), .level(lvl), .pin(pin),
    .rcClk(rcClk), .oscClk(oscClk));
  task automatic conclude();
    if (failCount == 0 && samplesChecked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // edges pass equal synchronisers, so one tick of slack either way
  task automatic near(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (!(got === exp || got === exp + 16'h1 || got + 16'h1 === exp)) begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cap(input logic [2:0] s, input logic fe, input logic be, input int w);
    sel <= s;
    lvl <= fe;
    repeat (8) @(posedge clk);
    bus(1'b1, ACTL, {24'h0, 2'b10, fe, be, 1'b0, s});
    bus(1'b0, ACTL, 32'h0);
    chk(rdv[7], 1'b1);
    @(posedge clk);
    lvl <= ~fe;
    if (fe == be) begin
      repeat (w / 2) @(posedge clk);
      lvl <= fe;
      repeat (w - w / 2) @(posedge clk);
      lvl <= ~fe;
    end else begin
      repeat (w) @(posedge clk);
      lvl <= fe;
    end
    repeat (50) begin
      bus(1'b0, ACTL, 32'h0);
      if (rdv[7] === 1'b0) break;
    end
    chk(rdv[7], 1'b0);
    bus(1'b0, {OFS_RESULT_HIGH, 2'b00}, 32'h0);
    res[15:8] = rdv[7:0];
    bus(1'b0, {OFS_RESULT_LOW, 2'b00}, 32'h0);
    res[7:0] = rdv[7:0];
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      failCount++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 6; i++) begin
      bus(1'b0, ACTL + 10'(4 * i), 32'h0);
      chk({erv, rdv}, 33'h0);
    end
    bus(1'b0, 10'h3fc, 32'h0);
    chk({erv, rdv}, 33'h100000000);
    bus(1'b1, 10'h0d1, 32'h85);
    bus(1'b0, ACTL, 32'h0);
    chk(rdv, 32'h0);
    bus(1'b1, AST + 10'h4, 32'h3);
    for (i = 0; i < 24; i++) begin
      cap(3'(i / 4), i[1], i[0], 40);
      near(res, 16'd40);
      chk(irq, 1'b1);
      bus(1'b1, AST, 32'h3);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
    end
    for (i = 0; i < 6; i++) begin
      bus(1'b1, ACS, 32'(i < 4 ? i : 4 * (i - 3)));
      cap(3'h0, 1'b0, 1'b1, i < 4 ? 256 : 160);
      near(res, i < 4 ? 16'(256 >> (2 * i)) : 16'(40 / (i - 3) / 2));
    end
    bus(1'b1, ACTL, 32'h86);
    lvl <= ~lvl;
    repeat (20) @(posedge clk);
    lvl <= ~lvl;
    bus(1'b0, ACTL, 32'h0);
    chk(rdv[7], 1'b1);
    bus(1'b1, ACTL, 32'h0);
    bus(1'b0, ACTL, 32'h0);
    chk(rdv[7], 1'b0);
    bus(1'b1, ACS, 32'h0);
    bus(1'b1, AST + 10'h4, 32'h0);
    cap(3'h0, 1'b0, 1'b1, 66000);
    near(res, 16'd464);
    bus(1'b0, ACTL, 32'h0);
    chk(rdv[7:6], 2'b01);
    bus(1'b0, AST, 32'h0);
    chk({irq, rdv[1:0]}, 3'b011);
    bus(1'b1, ACTL, 32'h40);
    bus(1'b0, ACTL, 32'h0);
    chk(rdv[6], 1'b1);
    bus(1'b1, ACTL, 32'h0);
    bus(1'b0, ACTL, 32'h0);
    chk(rdv[6], 1'b0);
    conclude();
  end
endmodule // pwc_capture_tb
